// file: hw/lpsel_regs.svh
`ifndef LPSEL_REGS_SVH
`define LPSEL_REGS_SVH

// register offsets on the plain register port
`define LPSEL_ADDR_W 9
`define LPSEL_OFF_SEG_SELECT 9'h10d
`define LPSEL_OFF_PRESCALE 9'h10e
`define LPSEL_OFF_CONTROL 9'h10f
`define LPSEL_OFF_PIXEL_BASE 9'h110
`define LPSEL_OFF_PIXEL_LAST 9'h11f
`define LPSEL_OFF_DIR_BASE 9'h120
`define LPSEL_OFF_DIR_LAST 9'h123

// reset values
`define LPSEL_RST_SEG_SELECT 8'hff
`define LPSEL_RST_PRESCALE 4'h0
`define LPSEL_RST_CONTROL 8'h00
`define LPSEL_RST_DIR 8'hff

// field positions and masks
`define LPSEL_CTRL_MUX_LSB 0
`define LPSEL_CTRL_MUX_MSB 1
`define LPSEL_CTRL_RSVD_MASK 8'hdf
`define LPSEL_PS_MASK 8'h0f

// geometry
`define LPSEL_PIXEL_BYTES 16
`define LPSEL_SEGMENTS 32
`define LPSEL_DIR_REGS 4
`define LPSEL_GROUPS 8
`define LPSEL_SHARED_COMMONS 3

`endif

// file: hw/lpsel_pkg.sv
package lpsel_pkg;

    // common multiplex select encodings
    typedef enum logic [1:0] {
        LPSEL_MUX_STATIC = 2'b00,
        LPSEL_MUX_HALF = 2'b01,
        LPSEL_MUX_THIRD = 2'b10,
        LPSEL_MUX_QUARTER = 2'b11
    } lpsel_mux_e;

    // what the block drives towards the pin side
    typedef struct packed {
        logic [31:0] lcd_drive;
        logic [2:0] common_drive;
        logic [31:0] digital_out_en;
    } lpsel_pins_s;

    // what the block hands to the waveform generator
    typedef struct packed {
        logic [127:0] pixel_bits;
        logic [1:0] common_multiplex_select;
        logic [7:0] control;
        logic [3:0] prescale;
    } lpsel_wave_s;

    // all state of the top module
    typedef struct packed {
        logic [127:0] pixel_state_bytes;
        logic [7:0] segment_pin_function_select;
        logic [7:0] display_control_register;
        logic [3:0] display_prescale_register;
        logic [31:0] port_direction_bits;
        logic [7:0] rdata;
        lpsel_pins_s pins;
        lpsel_wave_s wave;
    } lpsel_state_s;

endpackage

// file: hw/lpsel_top.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "lpsel_regs.svh"

module lpsel_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic external_master_clear,
    input wire logic watchdog_reset,
    input wire logic [8:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output lpsel_pkg::lpsel_pins_s pins,
    output lpsel_pkg::lpsel_wave_s wave
);

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic in_range(
        input logic [8:0] a,
        input logic [8:0] lo,
        input logic [8:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // single-register address match
    function automatic logic reg_hit(
        input logic [8:0] a,
        input logic [8:0] off
    );
        reg_hit = (a == off);
    endfunction

    // segment index to the enable bit that owns its group
    function automatic logic [2:0] group_of(
        input int unsigned seg
    );
        logic [2:0] g;
        g = 3'h0;
        case (seg)
            31, 30, 29: begin
                g = 3'h7;
            end
            28, 27: begin
                g = 3'h6;
            end
            26, 25, 24, 23, 22, 21, 20: begin
                g = 3'h5;
            end
            19, 18, 17, 16: begin
                g = 3'h4;
            end
            15, 14, 13, 12: begin
                g = 3'h3;
            end
            11, 10, 9: begin
                g = 3'h2;
            end
            8, 7, 6, 5: begin
                g = 3'h1;
            end
            default: begin
                g = 3'h0;
            end
        endcase
        group_of = g;
    endfunction

    // top segment pins claimed as common lines, lowest first
    function automatic logic [2:0] commons_claimed(
        input logic [1:0] m
    );
        logic [2:0] c;
        c = 3'h0;
        case (m)
            lpsel_pkg::LPSEL_MUX_STATIC: begin
                c = 3'h0;
            end
            lpsel_pkg::LPSEL_MUX_HALF: begin
                c = 3'h1;
            end
            lpsel_pkg::LPSEL_MUX_THIRD: begin
                c = 3'h3;
            end
            lpsel_pkg::LPSEL_MUX_QUARTER: begin
                c = 3'h7;
            end
            default: begin
                c = 3'h0;
            end
        endcase
        commons_claimed = c;
    endfunction

    // flat map, a simplification: segment pin s answers to direction bit s
    function automatic int unsigned dir_bit_of(
        input int unsigned seg
    );
        dir_bit_of = seg;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    lpsel_pkg::lpsel_state_s state_q;
    lpsel_pkg::lpsel_state_s state_d;

    logic [`LPSEL_SEGMENTS-1:0] seg_enable;
    logic [`LPSEL_SHARED_COMMONS-1:0] common_taken;
    logic [`LPSEL_SEGMENTS-1:0] lcd_owned;
    logic [`LPSEL_SEGMENTS-1:0] out_en;
    logic [1:0] mux_sel;
    logic is_pixel;
    logic is_dir;
    logic [3:0] pixel_idx;
    logic [1:0] dir_idx;
    logic reg_reset;
    logic [`LPSEL_GROUPS-1:0] group_en;

    // address decode and per-byte strobes
    logic hit_seg;
    logic hit_ctl;
    logic hit_ps;
    logic [`LPSEL_PIXEL_BYTES-1:0] pixel_we;
    logic [`LPSEL_DIR_REGS-1:0] dir_we;
    // byte views of the stores for the read mux
    logic [7:0] pixel_view [`LPSEL_PIXEL_BYTES];
    logic [7:0] dir_view [`LPSEL_DIR_REGS];

    localparam int unsigned FIRST_SHARED = `LPSEL_SEGMENTS - `LPSEL_SHARED_COMMONS;

    assign mux_sel = state_q.display_control_register[`LPSEL_CTRL_MUX_MSB:`LPSEL_CTRL_MUX_LSB];
    assign is_pixel = in_range(addr, `LPSEL_OFF_PIXEL_BASE, `LPSEL_OFF_PIXEL_LAST);
    assign is_dir = in_range(addr, `LPSEL_OFF_DIR_BASE, `LPSEL_OFF_DIR_LAST);
    assign pixel_idx = addr[3:0];
    assign dir_idx = addr[1:0];
    // power-on, master clear and watchdog all reset the control registers
    assign reg_reset = rst || external_master_clear || watchdog_reset;
    assign hit_seg = reg_hit(addr, `LPSEL_OFF_SEG_SELECT);
    assign hit_ctl = reg_hit(addr, `LPSEL_OFF_CONTROL);
    assign hit_ps = reg_hit(addr, `LPSEL_OFF_PRESCALE);
    assign group_en = state_q.segment_pin_function_select;

    ////////////////////////////////////////////////////////////////////////
    // byte write strobes and read views

    genvar b;
    generate
        for (b = 0; b < `LPSEL_PIXEL_BYTES; b = b + 1) begin : g_pix_we
            assign pixel_we[b] = wr && is_pixel && (pixel_idx == 4'(b));
            assign pixel_view[b] = state_q.pixel_state_bytes[b * 8 +: 8];
        end
        for (b = 0; b < `LPSEL_DIR_REGS; b = b + 1) begin : g_dir_we
            assign dir_we[b] = wr && is_dir && (dir_idx == 2'(b));
            assign dir_view[b] = state_q.port_direction_bits[b * 8 +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin function per segment pin

    // multiplex outranks enables
    // commons one, two, three take segments 29, 30, 31 as mux grows
    assign common_taken = commons_claimed(mux_sel);

    genvar s;
    generate
        for (s = 0; s < `LPSEL_SEGMENTS; s = s + 1) begin : g_seg
            assign seg_enable[s] = group_en[group_of(s)];
            if (s >= FIRST_SHARED) begin : g_shared
                assign lcd_owned[s] = common_taken[s - FIRST_SHARED] || seg_enable[s];
            end else begin : g_plain
                // one drives glass, zero is port
                assign lcd_owned[s] = seg_enable[s];
            end
            assign out_en[s] = !lcd_owned[s] && !state_q.port_direction_bits[dir_bit_of(s)];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d = state_q;

        for (int n = 0; n < `LPSEL_PIXEL_BYTES; n++) begin
            if (pixel_we[n]) begin
                state_d.pixel_state_bytes[n * 8 +: 8] = wdata;
            end
        end
        if (wr && hit_seg) begin
            // software clears to get a port
            state_d.segment_pin_function_select = wdata;
        end
        if (wr && hit_ctl) begin
            state_d.display_control_register = wdata & `LPSEL_CTRL_RSVD_MASK;
        end
        if (wr && hit_ps) begin
            state_d.display_prescale_register = wdata[3:0];
        end
        for (int k = 0; k < `LPSEL_DIR_REGS; k++) begin
            if (dir_we[k]) begin
                state_d.port_direction_bits[k * 8 +: 8] = wdata;
            end
        end

        // read data stands only in the cycle after the strobe
        state_d.rdata = 8'h00;
        if (rd) begin
            if (is_pixel) begin
                state_d.rdata = pixel_view[pixel_idx];
            end else if (is_dir) begin
                state_d.rdata = dir_view[dir_idx];
            end else begin
                case (addr)
                    `LPSEL_OFF_SEG_SELECT: begin
                        state_d.rdata = state_q.segment_pin_function_select;
                    end
                    `LPSEL_OFF_CONTROL: begin
                        state_d.rdata = state_q.display_control_register;
                    end
                    `LPSEL_OFF_PRESCALE: begin
                        state_d.rdata = {4'h0, state_q.display_prescale_register};
                    end
                    default: begin
                        state_d.rdata = 8'h00;
                    end
                endcase
            end
        end

        // outputs follow the registers one cycle later
        state_d.pins.lcd_drive = lcd_owned;
        state_d.pins.common_drive = common_taken;
        state_d.pins.digital_out_en = out_en;
        state_d.wave.pixel_bits = state_q.pixel_state_bytes;
        state_d.wave.common_multiplex_select = mux_sel;
        state_d.wave.control = state_q.display_control_register;
        state_d.wave.prescale = state_q.display_prescale_register;

        // pixels untouched by any reset
        // wake-up needs no input: nothing here changes on it
        if (reg_reset) begin
            state_d.segment_pin_function_select = `LPSEL_RST_SEG_SELECT;
            state_d.port_direction_bits = {`LPSEL_DIR_REGS{`LPSEL_RST_DIR}};
            state_d.display_control_register = `LPSEL_RST_CONTROL;
            state_d.display_prescale_register = `LPSEL_RST_PRESCALE;
            state_d.rdata = 8'h00;
            // pins park as glass drivers, never as outputs
            state_d.pins.lcd_drive = {`LPSEL_SEGMENTS{1'b1}};
            state_d.pins.common_drive = 3'h0;
            state_d.pins.digital_out_en = {`LPSEL_SEGMENTS{1'b0}};
            state_d.wave.common_multiplex_select = 2'h0;
            state_d.wave.control = `LPSEL_RST_CONTROL;
            state_d.wave.prescale = `LPSEL_RST_PRESCALE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // pixel field has no reset term, so it powers up unknown
    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    assign rdata = state_q.rdata;
    assign pins = state_q.pins;
    assign wave = state_q.wave;

endmodule // lpsel_top

// file: dv/lpsel_panel.sv
`timescale 1ns/100ps
module lpsel_panel (
    input wire lpsel_pkg::lpsel_pins_s pins,
    output logic [31:0] seg_lines,
    output logic [2:0] com_lines
);
    assign com_lines = pins.common_drive & pins.lcd_drive[31:29];
    assign seg_lines = pins.lcd_drive & ~{com_lines, 29'h0};
endmodule // lpsel_panel

// file: dv/lpsel_chk.sv
`timescale 1ns/100ps
`include "lpsel_regs.svh"
module lpsel_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic external_master_clear,
    input wire logic watchdog_reset,
    input wire logic [8:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire lpsel_pkg::lpsel_pins_s pins,
    input wire lpsel_pkg::lpsel_wave_s wave
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ctl_rst;
    logic [1:0] mx;
    assign ctl_rst = external_master_clear | watchdog_reset;
    assign mx = wave.common_multiplex_select;
    ////////////////////
    rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("rdata not zero");
    ctl_bit5_a: assert property ($past(rd) && $past(addr) == `LPSEL_OFF_CONTROL |-> !rdata[5])
        else $error("control bit5 read high");
    ps_upper_a: assert property ($past(rd) && $past(addr) == `LPSEL_OFF_PRESCALE |-> rdata[7:4] == 4'h0)
        else $error("prescale upper bits set");
    reset_pins_a: assert property (ctl_rst |=> pins.lcd_drive == 32'hffffffff && pins.digital_out_en == 32'h0)
        else $error("pins not lcd after reset");
    reset_ctl_a: assert property (ctl_rst |=> wave.control == 8'h00 && wave.prescale == 4'h0)
        else $error("control not cleared");
    lcd_excl_a: assert property ((pins.lcd_drive & pins.digital_out_en) == 32'h0)
        else $error("lcd pin also output");
    common_map_a: assert property (pins.common_drive == {mx == 2'h3, mx[1], mx != 2'h0})
        else $error("common pins wrong");
    common_own_a: assert property ((pins.common_drive & ~pins.lcd_drive[31:29]) == 3'h0)
        else $error("common pin not lcd");
    pixel_rw_a: assert property (wr && addr >= `LPSEL_OFF_PIXEL_BASE && addr <= `LPSEL_OFF_PIXEL_LAST ##1
        rd && addr == $past(addr) |=> rdata == $past(wdata, 2)) else $error("pixel readback wrong");
    group_map_a: assert property (wr && addr == `LPSEL_OFF_SEG_SELECT && !ctl_rst ##1 !ctl_rst |=>
        pins.lcd_drive[4:0] == {5{$past(wdata[0], 2)}} && pins.lcd_drive[28:27] == {2{$past(wdata[6], 2)}})
        else $error("group pins wrong");
    cover property (ctl_rst);
    cover property (wr && addr == `LPSEL_OFF_SEG_SELECT && wdata == 8'h00);
    cover property (pins.common_drive == 3'h7);
endmodule // lpsel_chk

// file: dv/lpsel_tb_top.sv
`timescale 1ns/100ps
`include "lpsel_regs.svh"
module lpsel_tb_top;
    localparam logic [8:0] a_seg = `LPSEL_OFF_SEG_SELECT;
    localparam logic [8:0] a_ctl = `LPSEL_OFF_CONTROL;
    localparam logic [8:0] a_ps = `LPSEL_OFF_PRESCALE;
    localparam logic [8:0] a_pix = `LPSEL_OFF_PIXEL_BASE;
    localparam logic [8:0] a_dir = `LPSEL_OFF_DIR_BASE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic external_master_clear = 1'b0;
    logic watchdog_reset = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    lpsel_pkg::lpsel_pins_s pins;
    lpsel_pkg::lpsel_wave_s wave;
    logic [31:0] seg_lines;
    logic [2:0] com_lines;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h00000027;
    logic [7:0] pix [16];
    logic [31:0] dir;
    always #4 clk = ~clk;
    lpsel_top lpsel_top_i (.clk(clk), .rst(rst), .external_master_clear(external_master_clear),
        .watchdog_reset(watchdog_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pins(pins), .wave(wave));
    lpsel_panel lpsel_panel_i (.pins(pins), .seg_lines(seg_lines), .com_lines(com_lines));
    ////////////////////
    function automatic logic [7:0] rnd8();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction
    // lcd pins owned by one enable bit
    function automatic logic [31:0] grp_mask(input int g);
        case (g)
            0: return 32'h0000001f;
            1: return 32'h000001e0;
            2: return 32'h00000e00;
            3: return 32'h0000f000;
            4: return 32'h000f0000;
            5: return 32'h07f00000;
            6: return 32'h18000000;
            default: return 32'he0000000;
        endcase
    endfunction
    function automatic logic [31:0] com_exp(input logic [1:0] m);
        return {29'h0, m == 2'h3, m[1], m != 2'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read data lands at the strobe edge, taken just after it
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({24'h0, rdata}, {24'h0, e});
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick();
        rd_chk(a_seg, 8'hff);
        rd_chk(a_ctl, 8'h00);
        rd_chk(a_ps, 8'h00);
        for (int k = 0; k < 4; k++) rd_chk(a_dir + 9'(k), 8'hff);
        check(pins.lcd_drive, 32'hffffffff);
        wr_reg(a_ctl, 8'hfc);
        rd_chk(a_ctl, 8'hdc);
        check({24'h0, wave.control}, 32'h000000dc);
        wr_reg(a_ps, 8'hff);
        rd_chk(a_ps, 8'h0f);
        check({28'h0, wave.prescale}, 32'h0000000f);
        wr_reg(9'h1ff, 8'h5a);
        rd_chk(9'h1ff, 8'h00);
        for (int n = 0; n < 16; n++) begin
            pix[n] = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : rnd8();
            wr_reg(a_pix + 9'(n), pix[n]);
            rd_chk(a_pix + 9'(n), pix[n]);
        end
        for (int n = 0; n < 16; n++) check({24'h0, wave.pixel_bits[8*n +: 8]}, {24'h0, pix[n]});
        for (int k = 0; k < 4; k++) wr_reg(a_dir + 9'(k), 8'h00);
        wr_reg(a_ctl, 8'h00);
        for (int g = 0; g < 8; g++) begin
            wr_reg(a_seg, 8'h01 << g);
            tick();
            check(pins.lcd_drive, grp_mask(g));
            check(pins.digital_out_en, ~grp_mask(g));
        end
        // all groups cleared for port use, commons still claim the top pins
        wr_reg(a_seg, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr_reg(a_ctl, 8'(m));
            tick();
            check({29'h0, com_lines}, com_exp(2'(m)));
            check({30'h0, wave.common_multiplex_select}, 32'(m));
        end
        wr_reg(a_ctl, 8'h00);
        dir = {rnd8(), rnd8(), rnd8(), rnd8()};
        for (int k = 0; k < 4; k++) wr_reg(a_dir + 9'(k), dir[8*k +: 8]);
        tick();
        check(pins.digital_out_en, ~dir);
        wr_reg(a_seg, 8'hff);
        tick();
        check(pins.digital_out_en, 32'h0);
        check(seg_lines, 32'hffffffff);
        for (int r = 0; r < 2; r++) begin
            wr_reg(a_seg, 8'h00);
            if (r == 0) external_master_clear <= 1'b1;
            else watchdog_reset <= 1'b1;
            tick();
            external_master_clear <= 1'b0;
            watchdog_reset <= 1'b0;
            rd_chk(a_seg, 8'hff);
            rd_chk(a_dir + 9'h003, 8'hff);
            rd_chk(a_pix + 9'h002, pix[2]);
        end
        conclude();
    end
endmodule // lpsel_tb_top
bind lpsel_top lpsel_chk lpsel_chk_i (.clk(clk), .rst(rst), .external_master_clear(external_master_clear),
    .watchdog_reset(watchdog_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pins(pins), .wave(wave));
